/* File: logic/pchba_pkg.sv */
package pchba_pkg;

	////////////////////////////////////////////////////////////////////////////
	// widths and memory layout
	localparam int          AW            = 16;
	localparam int          DW            = 16;
	localparam int          OFF_W         = 6;
	localparam int          BLK_W         = AW - OFF_W;
	localparam int          BLK_BYTES     = 128;
	localparam logic [5:0]  OFF_LINK      = 6'h00;
	localparam logic [5:0]  OFF_FIRST     = 6'h01;
	localparam logic [5:0]  OFF_LAST      = 6'h3F;
	localparam logic [15:0] MM_BASE       = 16'h0000;
	localparam logic [15:0] ATTR_BASE     = 16'h0000;
	localparam logic [15:0] ATTR_OFS      = 16'h0400;
	localparam int          NUM_REGS      = 32;

	////////////////////////////////////////////////////////////////////////////
	// word indices of the hardware registers and path data ports
	localparam logic [4:0]  IDX_P0_SEL    = 5'h0C;
	localparam logic [4:0]  IDX_P0_OFF    = 5'h0D;
	localparam logic [4:0]  IDX_P1_SEL    = 5'h0E;
	localparam logic [4:0]  IDX_P1_OFF    = 5'h0F;
	localparam logic [4:0]  IDX_P0_DATA   = 5'h18;
	localparam logic [4:0]  IDX_P1_DATA   = 5'h19;
	localparam logic [4:0]  IDX_AUX_BASE  = 5'h1A;
	localparam logic [4:0]  IDX_AUX_OFF   = 5'h1B;
	localparam logic [4:0]  IDX_AUX_DATA  = 5'h1C;

	////////////////////////////////////////////////////////////////////////////
	// reset values and timing
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          IRQ_PULSE_NS  = 1000;
	localparam int          IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		PCHBA_IORD,
		PCHBA_IOWR,
		PCHBA_ATRD,
		PCHBA_ATWR
	} pchba_kind_t;

	typedef struct packed {
		pchba_kind_t     kind;
		logic [9:0]      addr;
		logic [DW-1:0]   data;
	} pchba_cyc_t;

	typedef struct packed {
		logic            req;
		logic            we;
		logic [AW-1:0]   addr;
		logic [DW-1:0]   wdata;
	} pchba_mem_t;

endpackage

/* File: logic/pchba_hcyc.sv */
module pchba_hcyc (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic [9:0]         ha,
	input  wire logic [15:0]        hd_in,
	input  wire logic               ce1_n,
	input  wire logic               reg_sel_n,
	input  wire logic               iord_n,
	input  wire logic               iowr_n,
	input  wire logic               oe_n,
	input  wire logic               we_n,
	input  wire logic               io_en,
	output pchba_pkg::pchba_cyc_t   cyc,
	output logic                    start,
	output logic                    act
);

	logic                  act_q;
	logic                  act_d;
	logic                  start_q;
	logic                  start_d;
	pchba_pkg::pchba_cyc_t cyc_q;
	pchba_pkg::pchba_cyc_t cyc_d;
	logic                  io_cyc;
	logic                  at_cyc;

	////////////////////////////////////////////////////////////////////////////
	// one registered stage stands for the synchronising wait
	always_comb begin
		io_cyc  = io_en && (!iord_n || !iowr_n);
		at_cyc  = !oe_n || !we_n;
		act_d   = !ce1_n && !reg_sel_n && (io_cyc || at_cyc);
		start_d = act_d && !act_q;
		cyc_d   = cyc_q;
		if (start_d) begin
			cyc_d.addr = ha;
			cyc_d.data = hd_in;
			if (!iord_n)
				cyc_d.kind = pchba_pkg::PCHBA_IORD;
			else if (!iowr_n)
				cyc_d.kind = pchba_pkg::PCHBA_IOWR;
			else if (!oe_n)
				cyc_d.kind = pchba_pkg::PCHBA_ATRD;
			else
				cyc_d.kind = pchba_pkg::PCHBA_ATWR;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			act_q   <= 1'b0;
			start_q <= 1'b0;
			cyc_q   <= '0;
		end else begin
			act_q   <= act_d;
			start_q <= start_d;
			cyc_q   <= cyc_d;
		end
	end

	assign cyc   = cyc_q;
	assign start = start_q;
	assign act   = act_q;

endmodule

/* File: logic/pchba_bpath.sv */
module pchba_bpath #(
	parameter int AW    = pchba_pkg::AW,
	parameter int OFF_W = pchba_pkg::OFF_W
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             set_blk,
	input  wire logic             set_off,
	input  wire logic [15:0]      val,
	input  wire logic             step,
	input  wire logic             link_ld,
	input  wire logic [15:0]      link_val,
	output logic [AW-1:0]         addr,
	output logic [AW-OFF_W-1:0]   blk,
	output logic [OFF_W-1:0]      off,
	output logic                  need_link,
	output logic                  at_end
);

	logic [AW-OFF_W-1:0] blk_q;
	logic [AW-OFF_W-1:0] blk_d;
	logic [OFF_W-1:0]    off_q;
	logic [OFF_W-1:0]    off_d;
	logic                link_q;
	logic                link_d;
	logic                end_q;
	logic                end_d;

	always_comb begin
		blk_d  = blk_q;
		off_d  = off_q;
		link_d = link_q;
		end_d  = end_q;
		if (set_blk) begin
			blk_d  = val[AW-OFF_W-1:0];
			off_d  = pchba_pkg::OFF_FIRST;
			link_d = 1'b0;
			end_d  = 1'b0;
		end else if (set_off) begin
			off_d = val[OFF_W-1:0];
		end else if (step && !end_q) begin
			// word 0 of every block holds the link, so the last word hands over
			if (off_q == pchba_pkg::OFF_LAST)
				link_d = 1'b1;
			else
				off_d = off_q + 1'b1;
		end else if (link_ld) begin
			link_d = 1'b0;
			if (link_val[AW-OFF_W-1:0] == '0) begin
				end_d = 1'b1;
			end else begin
				blk_d = link_val[AW-OFF_W-1:0];
				off_d = pchba_pkg::OFF_FIRST;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			blk_q  <= '0;
			off_q  <= pchba_pkg::OFF_FIRST;
			link_q <= 1'b0;
			end_q  <= 1'b1;
		end else begin
			blk_q  <= blk_d;
			off_q  <= off_d;
			link_q <= link_d;
			end_q  <= end_d;
		end
	end

	assign addr      = {blk_q, off_q};
	assign blk       = blk_q;
	assign off       = off_q;
	assign need_link = link_q;
	assign at_end    = end_q;

endmodule

/* File: logic/pchba_top.sv */
// Behaviour
// - writes posted, only synchronising wait inserted
// - pending posted write holds wait on accesses
// - memory reads wait through arbitration and access
// - path read triggers pre-read of next word
// - one pre-read holder, other memory reads invalidate
// - invalid pre-read forces full memory read
// - request line: ready/busy, then interrupt
// - level or pulse interrupt, level default
// - ready only after card table copied
// - 32 word registers in I/O space
// - hardware registers direct, aux setup write-only
// - every attribute cycle, and every I/O cycle after firmware init, gets a sync wait
// - memory-mapped registers live in RAM
// - attribute space lands at base plus 0x400
// - path pointer auto-increments per access
// - two independent buffer paths
// - buffers are 128-byte linked blocks
// - block end follows link in hardware
// - past buffer end: writes dropped
// - hardware register wait lasts one clock with the memory engine idle
// - cycles without register-space select ignored
// - input acknowledge on valid I/O reads
module pchba_top (
	input  wire logic           CLK_SYS,
	input  wire logic           RSTN,
	input  wire logic [9:0]     HA,
	input  wire logic [15:0]    HD_IN,
	output logic [15:0]         HD_OUT,
	output logic                HD_OE_N,
	input  wire logic           CE1_N,
	input  wire logic           REGISTER_SPACE_SELECT_N,
	input  wire logic           IORD_N,
	input  wire logic           IOWR_N,
	input  wire logic           OE_N,
	input  wire logic           WE_N,
	output logic                HOST_WAIT_LINE_N,
	output logic                INPUT_ACKNOWLEDGE_N,
	output logic                HOST_REQUEST_LINE_N,
	input  wire logic           CIS_COPY_DONE,
	input  wire logic           FW_INIT_DONE,
	input  wire logic           IRQ_SOURCE,
	input  wire logic           IRQ_PULSE_MODE,
	output logic                MEM_REQ,
	output logic                MEM_WE,
	output logic [15:0]         MEM_ADDR,
	output logic [15:0]         MEM_WDATA,
	input  wire logic           MEM_ACK,
	input  wire logic [15:0]    MEM_RDATA
);

	typedef enum {S_IDLE, S_HOLD, S_RD, S_DONE} pchba_hst_t;
	typedef enum {OP_WR, OP_HRD, OP_LINK, OP_PRE} pchba_op_t;

	pchba_pkg::pchba_cyc_t cyc;
	logic                  cyc_start;
	logic                  cyc_act;
	logic [15:0]           p_addr [2];
	logic [9:0]            p_blk [2];
	logic [5:0]            p_off [2];
	logic                  p_link [2];
	logic                  p_end [2];
	logic                  set_blk [2];
	logic                  set_off [2];
	logic                  step [2];
	logic                  link_ld [2];

	////////////////////////////////////////////////////////////////////////////
	// host cycle capture and the two buffer paths
	pchba_hcyc u_hcyc (
		.clk       (CLK_SYS),
		.rstn      (RSTN),
		.ha        (HA),
		.hd_in     (HD_IN),
		.ce1_n     (CE1_N),
		.reg_sel_n (REGISTER_SPACE_SELECT_N),
		.iord_n    (IORD_N),
		.iowr_n    (IOWR_N),
		.oe_n      (OE_N),
		.we_n      (WE_N),
		.io_en     (FW_INIT_DONE),
		.cyc       (cyc),
		.start     (cyc_start),
		.act       (cyc_act)
	);

	for (genvar p = 0; p < 2; p++) begin : g_path
		pchba_bpath u_path (
			.clk       (CLK_SYS),
			.rstn      (RSTN),
			.set_blk   (set_blk[p]),
			.set_off   (set_off[p]),
			.val       (cyc.data),
			.step      (step[p]),
			.link_ld   (link_ld[p]),
			.link_val  (MEM_RDATA),
			.addr      (p_addr[p]),
			.blk       (p_blk[p]),
			.off       (p_off[p]),
			.need_link (p_link[p]),
			.at_end    (p_end[p])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// decode of the captured cycle
	logic [4:0]  idx;
	logic        is_io;
	logic        is_rd;
	logic        is_path;
	logic        pth;
	logic        is_hw;
	logic [15:0] cyc_maddr;
	logic [15:0] aux_base_q;
	logic [15:0] aux_base_d;
	logic [15:0] aux_off_q;
	logic [15:0] aux_off_d;

	always_comb begin
		idx     = cyc.addr[5:1];
		is_io   = cyc.kind == pchba_pkg::PCHBA_IORD || cyc.kind == pchba_pkg::PCHBA_IOWR;
		is_rd   = cyc.kind == pchba_pkg::PCHBA_IORD || cyc.kind == pchba_pkg::PCHBA_ATRD;
		is_path = is_io && (idx == pchba_pkg::IDX_P0_DATA || idx == pchba_pkg::IDX_P1_DATA);
		pth     = idx == pchba_pkg::IDX_P1_DATA;
		is_hw   = is_io && (idx == pchba_pkg::IDX_P0_SEL || idx == pchba_pkg::IDX_P0_OFF
			|| idx == pchba_pkg::IDX_P1_SEL || idx == pchba_pkg::IDX_P1_OFF
			|| idx == pchba_pkg::IDX_AUX_BASE || idx == pchba_pkg::IDX_AUX_OFF);
		if (!is_io)
			cyc_maddr = pchba_pkg::ATTR_BASE + pchba_pkg::ATTR_OFS + {7'h00, cyc.addr[9:1]};
		else if (is_path)
			cyc_maddr = p_addr[pth];
		else if (idx == pchba_pkg::IDX_AUX_DATA)
			cyc_maddr = aux_base_q + aux_off_q;
		else
			cyc_maddr = pchba_pkg::MM_BASE + {11'h000, idx};
	end

	////////////////////////////////////////////////////////////////////////////
	// memory engine: posted write, host read, link fetch, pre-read
	logic         busy_q, busy_d;
	pchba_op_t    op_q, op_d;
	logic         op_p_q, op_p_d;
	pchba_pkg::pchba_mem_t mem_q, mem_d;
	logic         pw_q, pw_d;
	logic [15:0]  pw_addr_q, pw_addr_d;
	logic [15:0]  pw_data_q, pw_data_d;
	logic         hrd_q, hrd_d;
	logic         pre_req_q, pre_req_d;
	logic         pre_p_q, pre_p_d;
	logic         pre_v_q, pre_v_d;
	logic [15:0]  pre_data_q, pre_data_d;
	logic         eng_idle;
	logic         hrd_ack;
	// requests from the host side
	logic         pw_set;
	logic         hrd_set;
	logic         pre_set;
	logic         pre_inval;

	always_comb begin
		busy_d     = busy_q;
		op_d       = op_q;
		op_p_d     = op_p_q;
		mem_d      = mem_q;
		pw_d       = pw_q || pw_set;
		pw_addr_d  = pw_set ? cyc_maddr : pw_addr_q;
		pw_data_d  = pw_set ? cyc.data : pw_data_q;
		hrd_d      = hrd_q || hrd_set;
		pre_req_d  = pre_req_q || pre_set;
		pre_p_d    = pre_set ? pth : pre_p_q;
		pre_v_d    = pre_inval ? 1'b0 : pre_v_q;
		pre_data_d = pre_data_q;
		hrd_ack    = 1'b0;
		for (int p = 0; p < 2; p++)
			link_ld[p] = 1'b0;
		if (busy_q) begin
			if (MEM_ACK) begin
				busy_d    = 1'b0;
				mem_d.req = 1'b0;
				case (op_q)
					OP_WR:   pw_d = 1'b0;
					OP_HRD: begin
						hrd_d   = 1'b0;
						hrd_ack = 1'b1;
					end
					OP_LINK: link_ld[op_p_q] = 1'b1;
					OP_PRE: begin
						pre_req_d  = 1'b0;
						pre_v_d    = 1'b1;
						pre_data_d = MEM_RDATA;
					end
					default: busy_d = 1'b0;
				endcase
			end
		end else if (pw_q) begin
			busy_d = 1'b1;
			op_d   = OP_WR;
			mem_d  = '{req: 1'b1, we: 1'b1, addr: pw_addr_q, wdata: pw_data_q};
		end else if (p_link[0] || p_link[1]) begin
			busy_d = 1'b1;
			op_d   = OP_LINK;
			op_p_d = !p_link[0];
			mem_d  = '{req: 1'b1, we: 1'b0, addr: {p_blk[!p_link[0]], pchba_pkg::OFF_LINK},
				wdata: pchba_pkg::RST_WORD};
		end else if (hrd_q) begin
			busy_d = 1'b1;
			op_d   = OP_HRD;
			mem_d  = '{req: 1'b1, we: 1'b0, addr: cyc_maddr, wdata: pchba_pkg::RST_WORD};
		end else if (pre_req_q) begin
			// no pre-read past the buffer end: that data is undefined anyway
			if (p_end[pre_p_q]) begin
				pre_req_d = 1'b0;
			end else begin
				busy_d = 1'b1;
				op_d   = OP_PRE;
				mem_d  = '{req: 1'b1, we: 1'b0, addr: p_addr[pre_p_q],
					wdata: pchba_pkg::RST_WORD};
			end
		end
		eng_idle = !busy_q && !pw_q && !p_link[0] && !p_link[1] && !pre_req_q;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			busy_q     <= 1'b0;
			op_q       <= OP_WR;
			op_p_q     <= 1'b0;
			mem_q      <= '0;
			pw_q       <= 1'b0;
			pw_addr_q  <= pchba_pkg::RST_WORD;
			pw_data_q  <= pchba_pkg::RST_WORD;
			hrd_q      <= 1'b0;
			pre_req_q  <= 1'b0;
			pre_p_q    <= 1'b0;
			pre_v_q    <= 1'b0;
			pre_data_q <= pchba_pkg::RST_WORD;
		end else begin
			busy_q     <= busy_d;
			op_q       <= op_d;
			op_p_q     <= op_p_d;
			mem_q      <= mem_d;
			pw_q       <= pw_d;
			pw_addr_q  <= pw_addr_d;
			pw_data_q  <= pw_data_d;
			hrd_q      <= hrd_d;
			pre_req_q  <= pre_req_d;
			pre_p_q    <= pre_p_d;
			pre_v_q    <= pre_v_d;
			pre_data_q <= pre_data_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// host cycle sequencer
	pchba_hst_t  st_q, st_d;
	logic [15:0] hd_q, hd_d;
	logic        oe_n_q, oe_n_d;
	logic        wait_n_q, wait_n_d;
	logic        inpack_n_q, inpack_n_d;

	always_comb begin
		st_d       = st_q;
		hd_d       = hd_q;
		aux_base_d = aux_base_q;
		aux_off_d  = aux_off_q;
		pw_set     = 1'b0;
		hrd_set    = 1'b0;
		pre_set    = 1'b0;
		pre_inval  = 1'b0;
		for (int p = 0; p < 2; p++) begin
			set_blk[p] = 1'b0;
			set_off[p] = 1'b0;
			step[p]    = 1'b0;
		end
		case (st_q)
			S_IDLE: if (cyc_start) st_d = S_HOLD;
			// waits here while a posted write or chain walk is still open
			S_HOLD: if (eng_idle) begin
				st_d = S_DONE;
				if (!is_rd) begin
					if (is_hw) begin
						set_blk[0] = idx == pchba_pkg::IDX_P0_SEL;
						set_off[0] = idx == pchba_pkg::IDX_P0_OFF;
						set_blk[1] = idx == pchba_pkg::IDX_P1_SEL;
						set_off[1] = idx == pchba_pkg::IDX_P1_OFF;
						if (idx == pchba_pkg::IDX_AUX_BASE)
							aux_base_d = cyc.data;
						if (idx == pchba_pkg::IDX_AUX_OFF)
							aux_off_d = cyc.data;
						pre_inval = (set_blk[pre_p_q] || set_off[pre_p_q]);
					end else if (!(is_path && p_end[pth])) begin
						pw_set = 1'b1;
						if (is_path) begin
							step[pth] = 1'b1;
							pre_inval = pre_p_q == pth;
						end
					end
				end else if (is_hw) begin
					case (idx)
						pchba_pkg::IDX_P0_SEL: hd_d = {p_end[0], 5'h00, p_blk[0]};
						pchba_pkg::IDX_P0_OFF: hd_d = {10'h000, p_off[0]};
						pchba_pkg::IDX_P1_SEL: hd_d = {p_end[1], 5'h00, p_blk[1]};
						pchba_pkg::IDX_P1_OFF: hd_d = {10'h000, p_off[1]};
						default:               hd_d = pchba_pkg::RST_WORD;
					endcase
				end else if (is_path && pre_v_q && pre_p_q == pth) begin
					hd_d      = pre_data_q;
					step[pth] = 1'b1;
					pre_set   = 1'b1;
					pre_inval = 1'b1;
				end else begin
					pre_inval = 1'b1;
					hrd_set   = 1'b1;
					st_d      = S_RD;
				end
			end
			S_RD: if (hrd_ack) begin
				hd_d = MEM_RDATA;
				st_d = S_DONE;
				if (is_path) begin
					step[pth] = 1'b1;
					pre_set   = 1'b1;
				end
			end
			S_DONE: if (!cyc_act) st_d = S_IDLE;
			default: st_d = S_IDLE;
		endcase
		wait_n_d   = !(st_d == S_HOLD || st_d == S_RD);
		oe_n_d     = !(st_d == S_DONE && is_rd && cyc_act);
		inpack_n_d = !(cyc_act && cyc.kind == pchba_pkg::PCHBA_IORD && FW_INIT_DONE);
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			st_q       <= S_IDLE;
			hd_q       <= pchba_pkg::RST_WORD;
			oe_n_q     <= 1'b1;
			wait_n_q   <= 1'b1;
			inpack_n_q <= 1'b1;
			aux_base_q <= pchba_pkg::RST_WORD;
			aux_off_q  <= pchba_pkg::RST_WORD;
		end else begin
			st_q       <= st_d;
			hd_q       <= hd_d;
			oe_n_q     <= oe_n_d;
			wait_n_q   <= wait_n_d;
			inpack_n_q <= inpack_n_d;
			aux_base_q <= aux_base_d;
			aux_off_q  <= aux_off_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request line: ready/busy first, interrupt after firmware init
	logic        src_q, src_d;
	logic [15:0] pcnt_q, pcnt_d;
	logic        hreq_n_q, hreq_n_d;

	always_comb begin
		src_d  = IRQ_SOURCE;
		pcnt_d = pcnt_q;
		// armed only in pulse mode: a later mode switch must not fire a stray pulse
		if (IRQ_SOURCE && !src_q && IRQ_PULSE_MODE)
			pcnt_d = 16'(pchba_pkg::IRQ_PULSE_CYC);
		else if (pcnt_q != 16'h0000)
			pcnt_d = pcnt_q - 16'h0001;
		if (!FW_INIT_DONE)
			hreq_n_d = CIS_COPY_DONE;
		else if (IRQ_PULSE_MODE)
			hreq_n_d = pcnt_d == 16'h0000;
		else
			hreq_n_d = !IRQ_SOURCE;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			src_q    <= 1'b0;
			pcnt_q   <= 16'h0000;
			hreq_n_q <= 1'b0;
		end else begin
			src_q    <= src_d;
			pcnt_q   <= pcnt_d;
			hreq_n_q <= hreq_n_d;
		end
	end

	assign HD_OUT              = hd_q;
	assign HD_OE_N             = oe_n_q;
	assign HOST_WAIT_LINE_N    = wait_n_q;
	assign INPUT_ACKNOWLEDGE_N = inpack_n_q;
	assign HOST_REQUEST_LINE_N = hreq_n_q;
	assign MEM_REQ             = mem_q.req;
	assign MEM_WE              = mem_q.we;
	assign MEM_ADDR            = mem_q.addr;
	assign MEM_WDATA           = mem_q.wdata;

endmodule

/* File: bench/pchba_chk.sv */
module pchba_chk (
	input wire logic        CLK_SYS,
	input wire logic        RSTN,
	input wire logic        CE1_N,
	input wire logic        REGISTER_SPACE_SELECT_N,
	input wire logic        IORD_N,
	input wire logic        IOWR_N,
	input wire logic        OE_N,
	input wire logic        HD_OE_N,
	input wire logic        HOST_WAIT_LINE_N,
	input wire logic        INPUT_ACKNOWLEDGE_N,
	input wire logic        HOST_REQUEST_LINE_N,
	input wire logic        CIS_COPY_DONE,
	input wire logic        FW_INIT_DONE,
	input wire logic        IRQ_SOURCE,
	input wire logic        IRQ_PULSE_MODE,
	input wire logic        MEM_REQ,
	input wire logic        MEM_WE,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [15:0] MEM_WDATA,
	input wire logic        MEM_ACK
);
	timeunit 1ns;
	timeprecision 1ns;
	logic io_go;
	// io strobes only count once the card is in io mode
	assign io_go = !CE1_N && !REGISTER_SPACE_SELECT_N && FW_INIT_DONE;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	////////////////////////////////////////////////////////////////////////////
	a_sync_wait: assert property (
		$fell(IORD_N & IOWR_N) && io_go |-> ##[2:3] !HOST_WAIT_LINE_N
	) else $error("io cycle got no sync wait");
	a_inpack_on: assert property (
		$fell(IORD_N) && io_go |-> ##[2:3] !INPUT_ACKNOWLEDGE_N
	) else $error("io read got no input acknowledge");
	a_inpack_cause: assert property (
		$fell(INPUT_ACKNOWLEDGE_N) |-> !IORD_N && io_go
	) else $error("input acknowledge without valid io read");
	a_refuse_idle: assert property (
		REGISTER_SPACE_SELECT_N [*4] |-> HOST_WAIT_LINE_N && HD_OE_N && INPUT_ACKNOWLEDGE_N
	) else $error("output moved without register select");
	a_oe_cause: assert property (
		$fell(HD_OE_N) |-> !REGISTER_SPACE_SELECT_N && !CE1_N && !(IORD_N && OE_N)
	) else $error("data driven outside a read cycle");
	a_busy_early: assert property (
		(!FW_INIT_DONE && !CIS_COPY_DONE) [*3] |-> !HOST_REQUEST_LINE_N
	) else $error("ready before card table copy");
	a_ready_late: assert property (
		(!FW_INIT_DONE && CIS_COPY_DONE) [*3] |-> HOST_REQUEST_LINE_N
	) else $error("not ready after card table copy");
	a_level_irq: assert property (
		(FW_INIT_DONE && !IRQ_PULSE_MODE && $stable(IRQ_SOURCE)) [*3]
		|-> HOST_REQUEST_LINE_N == !IRQ_SOURCE
	) else $error("level interrupt not following source");
	a_pulse_low: assert property (
		$rose(IRQ_SOURCE) && FW_INIT_DONE && IRQ_PULSE_MODE |-> ##2 (!HOST_REQUEST_LINE_N) [*8]
	) else $error("pulse interrupt too short");
	a_mem_hold: assert property (
		MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable({MEM_WE, MEM_ADDR, MEM_WDATA})
	) else $error("memory request changed before ack");
	a_mem_drop: assert property (
		MEM_REQ && MEM_ACK |=> !MEM_REQ
	) else $error("memory request held after ack");
endmodule

/* File: bench/pchba_mem.sv */
module pchba_mem (
	input  wire logic        clk,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	output logic             ack,
	output logic [15:0]      rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] ram [0:65535];
	int          lat = 3;
	int          cnt = 0;
	initial begin
		for (int i = 0; i < 65536; i++) ram[i] = 16'h0000;
		ack = 1'h0;
		rdata = 16'h0000;
	end
	// read data flips outside the ack cycle so a late sample is never lucky
	always @(posedge clk) begin
		ack <= 1'h0;
		rdata <= ~rdata;
		if (req && !ack) begin
			if (cnt >= lat) begin
				cnt <= 0;
				ack <= 1'h1;
				if (we) ram[addr] <= wdata;
				else rdata <= ram[addr];
			end else cnt <= cnt + 1;
		end
	end
endmodule

/* File: bench/pchba_top_tb.sv */
module pchba_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rstn, ce1_n, reg_n, iord_n, iowr_n, oe_n, we_n, cis, fw;
	logic        irq_src, pmode, hd_oe_n, wait_n, ack_n, req_n, m_req, m_we, m_ack;
	logic [9:0]  ha;
	logic [15:0] hd_in, hd_out, m_addr, m_wd, m_rd, q;
	int          num_errors, samples_checked, cycles, w;
	pchba_top i_dut (
		.CLK_SYS(clk), .RSTN(rstn), .HA(ha), .HD_IN(hd_in), .HD_OUT(hd_out),
		.HD_OE_N(hd_oe_n), .CE1_N(ce1_n), .REGISTER_SPACE_SELECT_N(reg_n),
		.IORD_N(iord_n), .IOWR_N(iowr_n), .OE_N(oe_n), .WE_N(we_n),
		.HOST_WAIT_LINE_N(wait_n), .INPUT_ACKNOWLEDGE_N(ack_n),
		.HOST_REQUEST_LINE_N(req_n), .CIS_COPY_DONE(cis), .FW_INIT_DONE(fw),
		.IRQ_SOURCE(irq_src), .IRQ_PULSE_MODE(pmode), .MEM_REQ(m_req), .MEM_WE(m_we),
		.MEM_ADDR(m_addr), .MEM_WDATA(m_wd), .MEM_ACK(m_ack), .MEM_RDATA(m_rd));
	pchba_mem i_mem (.clk(clk), .req(m_req), .we(m_we), .addr(m_addr), .wdata(m_wd),
		.ack(m_ack), .rdata(m_rd));
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("counts: %0d mismatches, %0d checks", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	function automatic logic [9:0] io(input logic [4:0] i);
		return {4'h0, i, 1'h0};
	endfunction
	// kind 0 io rd, 1 io wr, 2 attr rd, 3 attr wr, 4 io rd without select
	task automatic cyc(input int k, input logic [9:0] a, input logic [15:0] d);
		int n;
		n = 0;
		w = 0;
		ha = a;
		hd_in = d;
		ce1_n = 1'h0;
		reg_n = (k == 4);
		iord_n = !(k == 0 || k == 4);
		iowr_n = (k != 1);
		oe_n = (k != 2);
		we_n = (k != 3);
		do begin
			@(posedge clk);
			#1;
			n++;
			if (wait_n === 1'h0) w++;
		end while (n < 40 && !(w > 0 && wait_n === 1'h1));
		q = hd_out;
		if (k != 4) check("wait seen", {15'h0000, w > 0 && wait_n === 1'h1}, 16'h0001);
		if (k == 0 || k == 4) check("inpack", {15'h0000, ack_n}, {15'h0000, k == 4});
		if (k != 1 && k != 3) check("drive", {15'h0000, hd_oe_n}, {15'h0000, k == 4});
		step(1);
		{ce1_n, reg_n, iord_n, iowr_n, oe_n, we_n} = 6'h3F;
		ha = ~a;
		hd_in = ~d;
		step(3);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_ready();
		check("busy", {15'h0000, req_n}, 16'h0000);
		cis = 1'h1;
		step(3);
		check("ready", {15'h0000, req_n}, 16'h0001);
		fw = 1'h1;
		step(3);
		check("irq idle", {15'h0000, req_n}, 16'h0001);
		$display("test ready done");
	endtask
	task automatic t_hw();
		cyc(1, io(pchba_pkg::IDX_P0_SEL), 16'h0005);
		check("sel wr wait", 16'(w), 16'h0001);
		cyc(0, io(pchba_pkg::IDX_P0_SEL), 16'h0000);
		check("sel rd", q, 16'h0005);
		check("hw rd wait", 16'(w), 16'h0001);
		cyc(0, io(pchba_pkg::IDX_P0_OFF), 16'h0000);
		check("off rd", q, 16'h0001);
		cyc(1, io(pchba_pkg::IDX_AUX_BASE), 16'h1234);
		cyc(0, io(pchba_pkg::IDX_AUX_BASE), 16'h0000);
		check("aux base", q, 16'h0000);
		cyc(4, io(pchba_pkg::IDX_P0_SEL), 16'h0000);
		check("unselected wait", 16'(w), 16'h0000);
		$display("test hw done");
	endtask
	task automatic t_chain();
		for (int j = 1; j < 64; j++) begin
			i_mem.ram[16'h0140 + j] = 16'h5000 + 16'(j);
			i_mem.ram[16'h01C0 + j] = 16'h7000 + 16'(j);
		end
		i_mem.ram[16'h0140] = 16'h0007;
		i_mem.lat = 1;
		cyc(1, io(pchba_pkg::IDX_P0_SEL), 16'h0005);
		// host never steers across block ends itself
		for (int i = 0; i < 70; i++) begin
			cyc(0, io(pchba_pkg::IDX_P0_DATA), 16'h0000);
			check("p0 data", q, (i < 63) ? 16'h5001 + 16'(i) : 16'h6FC2 + 16'(i));
			if (i == 0) check("cold rd slow", {15'h0000, w > 1}, 16'h0001);
			if (i == 1) check("pre-read wait", 16'(w), 16'h0001);
		end
		$display("test chain done");
	endtask
	task automatic t_inval();
		i_mem.lat = 2;
		i_mem.ram[16'h0003] = 16'hBEEF;
		cyc(0, io(5'h03), 16'h0000);
		check("mm rd", q, 16'hBEEF);
		check("mm rd slow", {15'h0000, w > 1}, 16'h0001);
		cyc(0, io(pchba_pkg::IDX_P0_DATA), 16'h0000);
		check("p0 after mm", q, 16'h7008);
		check("refetch slow", {15'h0000, w > 1}, 16'h0001);
		cyc(1, io(pchba_pkg::IDX_P0_OFF), 16'h0002);
		cyc(0, io(pchba_pkg::IDX_P0_DATA), 16'h0000);
		check("p0 moved", q, 16'h7002);
		$display("test invalidate done");
	endtask
	task automatic t_post();
		i_mem.lat = 20;
		cyc(1, io(pchba_pkg::IDX_P1_SEL), 16'h0009);
		cyc(1, io(pchba_pkg::IDX_P1_DATA), 16'hA001);
		check("posted wait", 16'(w), 16'h0001);
		cyc(0, io(pchba_pkg::IDX_P0_SEL), 16'h0000);
		check("held by post", {15'h0000, w > 1}, 16'h0001);
		check("p0 sel", q, 16'h0007);
		check("post landed", i_mem.ram[16'h0241], 16'hA001);
		i_mem.lat = 1;
		cyc(1, io(pchba_pkg::IDX_P1_OFF), 16'h003F);
		cyc(1, io(pchba_pkg::IDX_P1_DATA), 16'hA0FF);
		cyc(1, io(pchba_pkg::IDX_P1_DATA), 16'hA100);
		step(8);
		check("last word", i_mem.ram[16'h027F], 16'hA0FF);
		check("past end", i_mem.ram[16'h0001], 16'h0000);
		cyc(0, io(pchba_pkg::IDX_P0_DATA), 16'h0000);
		check("p0 kept", q, 16'h7003);
		$display("test post done");
	endtask
	task automatic t_attr();
		i_mem.ram[16'h0403] = 16'hA5A5;
		cyc(2, 10'h006, 16'h0000);
		check("attr rd", q, 16'hA5A5);
		cyc(3, 10'h008, 16'h5A5A);
		check("attr wr wait", 16'(w), 16'h0001);
		step(6);
		check("attr wr", i_mem.ram[16'h0404], 16'h5A5A);
		$display("test attr done");
	endtask
	task automatic t_irq();
		int n;
		irq_src = 1'h1;
		step(10);
		check("level held", {15'h0000, req_n}, 16'h0000);
		irq_src = 1'h0;
		step(3);
		check("level off", {15'h0000, req_n}, 16'h0001);
		pmode = 1'h1;
		step(1);
		check("no stray pulse", {15'h0000, req_n}, 16'h0001);
		irq_src = 1'h1;
		n = 0;
		repeat (60) begin
			step(1);
			if (req_n === 1'h0) n++;
		end
		check("pulse len", 16'(n), 16'(pchba_pkg::IRQ_PULSE_CYC));
		irq_src = 1'h0;
		$display("test irq done");
	endtask
	initial begin
		{clk, rstn, cis, fw, irq_src, pmode} = 6'h00;
		{ce1_n, reg_n, iord_n, iowr_n, oe_n, we_n} = 6'h3F;
		ha = 10'h000;
		hd_in = 16'h0000;
		num_errors = 0;
		samples_checked = 0;
		cycles = 0;
		step(8);
		rstn = 1'h1;
		t_ready();
		t_hw();
		t_chain();
		t_inval();
		t_post();
		t_attr();
		t_irq();
		close_out();
	end
endmodule
bind pchba_top pchba_chk i_chk (.CLK_SYS, .RSTN, .CE1_N, .REGISTER_SPACE_SELECT_N, .IORD_N,
	.IOWR_N, .OE_N, .HD_OE_N, .HOST_WAIT_LINE_N, .INPUT_ACKNOWLEDGE_N, .HOST_REQUEST_LINE_N,
	.CIS_COPY_DONE, .FW_INIT_DONE, .IRQ_SOURCE, .IRQ_PULSE_MODE, .MEM_REQ, .MEM_WE,
	.MEM_ADDR, .MEM_WDATA, .MEM_ACK);
